// ---- shared/cfg_defs_defs.svh ----
// offsets, field positions, reset values and timing counts of the config bank
// assumes a 20 MHz sys_clk and one aligned AHB-Lite word per register
`ifndef CFG_DEFS_DEFS_SVH
`define CFG_DEFS_DEFS_SVH
`define IDX_DEVICE_CFG   6'h0e
`define IDX_POWER_CFG    6'h0f
`define IDX_LINK_CFG     6'h10
`define IDX_IRQ_STATUS   6'h20
`define IDX_IRQ_ENABLE   6'h21
`define IDX_IRQ_CLEAR    6'h22
`define IDX_ADDR_CTRL    6'h23
`define HSIZE_WORD       3'h2
`define DEV_HI           5
`define DEV_ADDR_SEL_BIT 4
`define PWR_PCTL_BIT     7
`define LNK_BAUD_HI      13
`define LNK_BAUD_LO      12
`define LNK_EN_HI        7
`define LNK_EN_LO        3
`define ADDR_CTRL_BIT    0
`define DEV_DEFINED_MASK 32'h0000003f
`define PWR_DEFINED_MASK 32'h00000080
`define LNK_DEFINED_MASK 32'h000030f8
`define DEV_CFG_RESET    6'h00
`define PWR_PCTL_RESET   1'h0
`define LNK_CFG_RESET    16'h10f8
`define BAUD_COMM_RESET  2'h1
`define IRQ_N            4
`define IRQ_CONV         0
`define IRQ_RSVD         1
`define IRQ_COMMRST      2
`define IRQ_AUTOADDR     3
`define CLK_FREQ_KHZ     20000
`define FE_DELAY_US      100
`define FE_DELAY_CYC     ((`FE_DELAY_US * `CLK_FREQ_KHZ + 999) / 1000)
`define FE_CNT_W         12
`define BAUD0_KBAUD      125
`define BAUD1_KBAUD      250
`define BAUD2_KBAUD      500
`define BAUD3_KBAUD      1000
`define BIT_CNT_W        8
`endif

// ---- shared/cfg_pkg.sv ----
// types shared by the configuration bank and its helpers
// no state; compiled before every design module
package cfg_pkg;
	typedef struct packed {
		logic       reg_disable;
		logic       addr_sel;
		logic [1:0] comp_cfg;
		logic       hyst_on;
		logic       fault_autoclear;
	} dev_cfg_t;
	typedef struct packed {
		logic [1:0] baud;
		logic       host_tx_en;
		logic       upper_rx_en;
		logic       lower_tx_en;
		logic       upper_fault_rx_en;
		logic       heartbeat_en;
	} link_cfg_t;
	typedef struct packed {
		logic over_limit_en;
		logic under_limit_en;
		logic hysteresis_on;
	} comp_ctrl_t;
	typedef enum logic [1:0] {
		CMP_BOTH,
		CMP_OVER_ONLY,
		CMP_NONE,
		CMP_RESERVED
	} comp_mode_t;
	typedef enum logic {
		FE_IDLE,
		FE_WAIT
	} fe_state_t;
endpackage : cfg_pkg

// ---- logic/sample_delay.sv ----
// front-end power-up delay between a sample request and conversion start
// assumes sample_request is a one-cycle pulse on sys_clk
`timescale 1ns/100ps
`include "cfg_defs_defs.svh"
module sample_delay (
	input  wire logic sys_clk,        // device clock
	input  wire logic reset,          // sync, active high
	input  wire logic pctl_en,        // applied power control
	input  wire logic sample_request, // sampling request pulse
	output logic      conv_start,     // conversion start pulse
	output logic      fe_busy         // delay running
);
	import cfg_pkg::*;
	fe_state_t            state_q;
	logic [`FE_CNT_W-1:0] count_q;

	// requests during the delay are dropped
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q    <= FE_IDLE;
			count_q    <= '0;
			conv_start <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			case (state_q)
				FE_IDLE: begin
					if (sample_request && pctl_en) begin
						state_q <= FE_WAIT; // [RL9]
						count_q <= `FE_CNT_W'(`FE_DELAY_CYC - 1);
					end else if (sample_request) begin
						conv_start <= 1'b1;
					end
				end
				FE_WAIT: begin
					if (count_q == '0) begin
						state_q    <= FE_IDLE;
						conv_start <= 1'b1; // [RL9]
					end else begin
						count_q <= count_q - 1'b1;
					end
				end
				default: state_q <= FE_IDLE;
			endcase
		end
	end

	assign fe_busy = (state_q == FE_WAIT);
endmodule : sample_delay

// ---- logic/irq_bank.sv ----
// sticky event flags, enable mask and write-one-to-clear
// assumes event and clear inputs are one-cycle pulses on sys_clk
`timescale 1ns/100ps
`include "cfg_defs_defs.svh"
module irq_bank (
	input  wire logic [`IRQ_N-1:0] event_in,  // event pulses
	input  wire logic [`IRQ_N-1:0] clear_in,  // clear pulses
	input  wire logic [`IRQ_N-1:0] enable_in, // mask
	input  wire logic              sys_clk,   // device clock
	input  wire logic              reset,     // sync, active high
	output logic      [`IRQ_N-1:0] status,    // sticky flags
	output logic                   irq        // level interrupt
);
	genvar i;
	generate
		for (i = 0; i < `IRQ_N; i++) begin : g_flag
			// a set in the clearing cycle wins
			always_ff @(posedge sys_clk) begin
				if (reset)
					status[i] <= 1'b0;
				else if (event_in[i])
					status[i] <= 1'b1;
				else if (clear_in[i])
					status[i] <= 1'b0;
			end
		end
	endgenerate

	assign irq = |(status & enable_in);
endmodule : irq_bank

// ---- logic/comm_config_regs.sv ----
// configuration bank: device, power and link settings behind AHB-Lite
// assumes one AHB-Lite master and input pulses synchronous to sys_clk
`timescale 1ns/100ps
`include "cfg_defs_defs.svh"

// Notes on behaviour
// [RL1] Host writes device configuration bits 7:6 as zero.
// [RL2] Bit 5 set turns the internal regulator off.
// [RL3] System reset fault flag forces the regulator on.
// [RL4] Bit 4 picks GPIO or auto addressing; address is kept.
// [RL5] Comparator field: 0 both, 1 over-limit only, 2 none, 3 reserved.
// [RL6] Bit 1 set enables comparator hysteresis.
// [RL7] Bit 0 set unlatches faults; clear keeps them latched.
// [RL8] Host changes autoclear only while no fault is set; the bank takes bit 0 on every device write.
// [RL9] Power control set delays each conversion by 100 us.
// [RL10] Power configuration applies after the next sample.
// [RL11] Line rate codes 0..3 give 125k..1M baud; comm reset gives 250k.
// [RL12] Host transmit off drives TX high, fault low, never floating.
// [RL13] Bit 6 enables the upper differential receiver.
// [RL14] Bit 5 enables the lower differential transmitter.
// [RL15] Bit 4 enables the upper fault receiver.
// [RL16] Bit 3 enables the fault output heartbeat.
// [RL17] Reserved link bits are written and read as zero.
// [RL18] Auto source plus auto-address write enters auto mode.
// [RL19] Fields hold until rewritten or reset; comm reset restores rate.
module comm_config_regs (
	input  wire logic        sys_clk,          // device clock
	input  wire logic        reset,            // sync, active high
	input  wire logic        hsel,             // slave select
	input  wire logic [31:0] haddr,            // byte address
	input  wire logic [1:0]  htrans,           // transfer type
	input  wire logic        hwrite,           // write when high
	input  wire logic [2:0]  hsize,            // transfer size
	input  wire logic [31:0] hwdata,           // write data
	input  wire logic        hready,           // bus ready
	output logic             hreadyout,        // slave ready
	output logic             hresp,            // always okay
	output logic      [31:0] hrdata,           // read data
	input  wire logic        comm_reset,       // communication reset pulse
	input  wire logic        system_reset_fault_flag, // fault flag level
	input  wire logic        sample_request,   // sampling request pulse
	input  wire logic        sample_taken,     // sample done pulse
	input  wire logic        frame_received,   // frame end pulse
	input  wire logic        host_tx_data,     // serial data to host
	input  wire logic        fault_n_in,       // fault output request
	output logic             regulator_enable, // regulator drive on
	output logic             address_source,   // 1 auto, 0 gpio
	output logic             addr_gpio_sample, // sample gpio pulse
	output logic             auto_address_mode, // auto addressing
	output cfg_pkg::comp_ctrl_t comp_ctrl,     // comparator controls
	output logic             fault_autoclear,  // unlatched faults
	output logic             frontend_power_control, // applied bit
	output logic             conv_start,       // conversion pulse
	output logic             frontend_busy,    // power-up delay
	output cfg_pkg::link_cfg_t link_cfg,       // link settings
	output logic             baud_tick,        // one per bit period
	output logic             tx_out,           // TX level
	output logic             tx_oe,            // TX driven
	output logic             fault_n_out,      // fault pin level
	output logic             fault_n_oe,       // fault pin driven
	output logic             irq               // level interrupt
);
	import cfg_pkg::*;

	localparam logic [15:0] LNK_RST = `LNK_CFG_RESET;

	logic        dp_valid_q;
	logic        dp_write_q;
	logic [5:0]  dp_index_q;
	logic        rd_pending_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_data_d;
	logic        ap_take;
	logic        ap_ok;

	dev_cfg_t    dev_q;
	logic        pctl_written_q;
	logic        pctl_applied_q;
	link_cfg_t   link_q;
	logic [`IRQ_N-1:0] irq_enable_q;
	logic        auto_mode_q;
	logic        gpio_sample_q;
	logic        regulator_q;
	comp_ctrl_t  comp_q;
	logic        tx_q;
	logic        fault_n_q;
	logic [`BIT_CNT_W-1:0] bit_cnt_q;
	logic        baud_tick_q;

	logic        wr_dev;
	logic        wr_pwr;
	logic        wr_link;
	logic        wr_en;
	logic        wr_clr;
	logic        wr_addr;
	logic        auto_set;
	logic        auto_exit;
	logic        rsvd_hit;
	logic        conv_pulse;
	logic [`IRQ_N-1:0] irq_event;
	logic [`IRQ_N-1:0] irq_clear;
	logic [`IRQ_N-1:0] irq_status;

	function automatic logic is_index(input logic [5:0] idx,
		input logic [5:0] target);
		is_index = (idx == target);
	endfunction : is_index

	function automatic comp_ctrl_t decode_comp(input comp_mode_t mode,
		input logic hyst);
		comp_ctrl_t c;
		c = '0;
		c.hysteresis_on = hyst; // [RL6]
		case (mode)
			CMP_BOTH: begin
				c.over_limit_en  = 1'b1;
				c.under_limit_en = 1'b1;
			end
			CMP_OVER_ONLY: begin
				c.over_limit_en = 1'b1;
			end
			// reserved code leaves comparators off
			default: begin
				c.over_limit_en  = 1'b0;
				c.under_limit_en = 1'b0;
			end
		endcase
		decode_comp = c;
	endfunction : decode_comp

	function automatic logic [`BIT_CNT_W-1:0] bit_cycles(input logic [1:0] code);
		case (code)
			2'h0:    bit_cycles = `BIT_CNT_W'(`CLK_FREQ_KHZ / `BAUD0_KBAUD);
			2'h1:    bit_cycles = `BIT_CNT_W'(`CLK_FREQ_KHZ / `BAUD1_KBAUD);
			2'h2:    bit_cycles = `BIT_CNT_W'(`CLK_FREQ_KHZ / `BAUD2_KBAUD);
			default: bit_cycles = `BIT_CNT_W'(`CLK_FREQ_KHZ / `BAUD3_KBAUD);
		endcase
	endfunction : bit_cycles

	// reads get one wait state so read data is registered
	assign ap_take = hsel & htrans[1] & hready;
	assign ap_ok   = (haddr[31:8] == 24'h0) & (haddr[1:0] == 2'h0)
		& (hsize == `HSIZE_WORD);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dp_valid_q   <= 1'b0;
			dp_write_q   <= 1'b0;
			dp_index_q   <= 6'h00;
			rd_pending_q <= 1'b0;
		end else begin
			dp_valid_q   <= ap_take & ap_ok;
			dp_write_q   <= ap_take & ap_ok & hwrite;
			dp_index_q   <= haddr[7:2];
			rd_pending_q <= ap_take & ~hwrite;
		end
	end

	assign wr_dev  = dp_write_q & is_index(dp_index_q, `IDX_DEVICE_CFG);
	assign wr_pwr  = dp_write_q & is_index(dp_index_q, `IDX_POWER_CFG);
	assign wr_link = dp_write_q & is_index(dp_index_q, `IDX_LINK_CFG);
	assign wr_en   = dp_write_q & is_index(dp_index_q, `IDX_IRQ_ENABLE);
	assign wr_clr  = dp_write_q & is_index(dp_index_q, `IDX_IRQ_CLEAR);
	assign wr_addr = dp_write_q & is_index(dp_index_q, `IDX_ADDR_CTRL);

	// device configuration; bits 7:6 are not stored
	always_ff @(posedge sys_clk) begin
		if (reset)
			dev_q <= dev_cfg_t'(`DEV_CFG_RESET); // [RL19]
		else if (wr_dev)
			dev_q <= dev_cfg_t'(hwdata[`DEV_HI:0]); // [RL1] [RL7]
	end

	// power control: written copy, applied after next sample
	always_ff @(posedge sys_clk) begin
		if (reset)
			pctl_written_q <= `PWR_PCTL_RESET;
		else if (wr_pwr)
			pctl_written_q <= hwdata[`PWR_PCTL_BIT];
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			pctl_applied_q <= `PWR_PCTL_RESET;
		else if (sample_taken)
			pctl_applied_q <= pctl_written_q; // [RL10]
	end

	// comm reset rate wins over the rate field of a same-cycle link write; its enable bits still load
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			link_q <= link_cfg_t'({LNK_RST[`LNK_BAUD_HI:`LNK_BAUD_LO],
				LNK_RST[`LNK_EN_HI:`LNK_EN_LO]});
		end else begin
			if (wr_link)
				link_q <= link_cfg_t'({hwdata[`LNK_BAUD_HI:`LNK_BAUD_LO],
					hwdata[`LNK_EN_HI:`LNK_EN_LO]}); // [RL13] [RL14] [RL15] [RL16]
			if (comm_reset)
				link_q.baud <= `BAUD_COMM_RESET; // [RL11] [RL19]
		end
	end

	// bit-period timer at the selected line rate
	always_ff @(posedge sys_clk) begin
		if (reset || comm_reset || wr_link) begin
			bit_cnt_q   <= '0;
			baud_tick_q <= 1'b0;
		end else if (bit_cnt_q >= bit_cycles(link_q.baud) - 1'b1) begin
			bit_cnt_q   <= '0;
			baud_tick_q <= 1'b1; // [RL11]
		end else begin
			bit_cnt_q   <= bit_cnt_q + 1'b1;
			baud_tick_q <= 1'b0;
		end
	end

	// the held address is never touched here
	assign auto_set  = wr_addr & hwdata[`ADDR_CTRL_BIT] & dev_q.addr_sel;
	assign auto_exit = auto_mode_q & frame_received & ~auto_set;

	always_ff @(posedge sys_clk) begin
		if (reset)
			auto_mode_q <= 1'b0;
		else if (auto_set)
			auto_mode_q <= 1'b1; // [RL18]
		else if (frame_received)
			auto_mode_q <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			gpio_sample_q <= 1'b0;
		else
			gpio_sample_q <= wr_addr & hwdata[`ADDR_CTRL_BIT] & ~dev_q.addr_sel; // [RL4]
	end

	// registered device-side controls
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			regulator_q <= 1'b1;
			comp_q      <= '0;
		end else begin
			regulator_q <= ~dev_q.reg_disable | system_reset_fault_flag; // [RL2] [RL3]
			comp_q      <= decode_comp(comp_mode_t'(dev_q.comp_cfg), dev_q.hyst_on); // [RL5]
		end
	end

	// host pins always driven, parked when disabled
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tx_q      <= 1'b1;
			fault_n_q <= 1'b0;
		end else if (link_q.host_tx_en) begin
			tx_q      <= host_tx_data;
			fault_n_q <= fault_n_in;
		end else begin
			tx_q      <= 1'b1; // [RL12]
			fault_n_q <= 1'b0; // [RL12]
		end
	end

	// interrupt event sources
	always_comb begin
		rsvd_hit = 1'b0;
		if (wr_dev)
			rsvd_hit = |(hwdata & ~`DEV_DEFINED_MASK)
				| (comp_mode_t'(hwdata[3:2]) == CMP_RESERVED);
		else if (wr_pwr)
			rsvd_hit = |(hwdata & ~`PWR_DEFINED_MASK);
		else if (wr_link)
			rsvd_hit = |(hwdata & ~`LNK_DEFINED_MASK);
	end

	always_comb begin
		irq_event                = '0;
		irq_event[`IRQ_CONV]     = conv_pulse;
		irq_event[`IRQ_RSVD]     = rsvd_hit;
		irq_event[`IRQ_COMMRST]  = comm_reset;
		irq_event[`IRQ_AUTOADDR] = auto_exit;
	end

	assign irq_clear = wr_clr ? hwdata[`IRQ_N-1:0] : '0;

	always_ff @(posedge sys_clk) begin
		if (reset)
			irq_enable_q <= '0;
		else if (wr_en)
			irq_enable_q <= hwdata[`IRQ_N-1:0];
	end

	irq_bank u_irq (
		.event_in  (irq_event),
		.clear_in  (irq_clear),
		.enable_in (irq_enable_q),
		.sys_clk   (sys_clk),
		.reset     (reset),
		.status    (irq_status),
		.irq       (irq)
	);

	sample_delay u_delay (
		.sys_clk        (sys_clk),
		.reset          (reset),
		.pctl_en        (pctl_applied_q),
		.sample_request (sample_request),
		.conv_start     (conv_pulse),
		.fe_busy        (frontend_busy)
	);

	// unlisted and reserved bits read zero
	always_comb begin
		rd_data_d = 32'h0;
		if (dp_valid_q) begin
			case (dp_index_q)
				`IDX_DEVICE_CFG: begin
					rd_data_d[`DEV_HI:0] = dev_q; // [RL1]
				end
				`IDX_POWER_CFG: begin
					rd_data_d[`PWR_PCTL_BIT] = pctl_written_q;
				end
				`IDX_LINK_CFG: begin
					rd_data_d[`LNK_BAUD_HI:`LNK_BAUD_LO] = link_q.baud;
					rd_data_d[`LNK_EN_HI:`LNK_EN_LO] = {link_q.host_tx_en,
						link_q.upper_rx_en, link_q.lower_tx_en,
						link_q.upper_fault_rx_en, link_q.heartbeat_en}; // [RL17]
				end
				`IDX_IRQ_STATUS: begin
					rd_data_d[`IRQ_N-1:0] = irq_status;
				end
				`IDX_IRQ_ENABLE: begin
					rd_data_d[`IRQ_N-1:0] = irq_enable_q;
				end
				`IDX_ADDR_CTRL: begin
					rd_data_d[`ADDR_CTRL_BIT] = auto_mode_q;
				end
				default: begin
					rd_data_d = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			hrdata_q <= 32'h0;
		else if (rd_pending_q)
			hrdata_q <= rd_data_d;
	end

	assign hreadyout              = ~rd_pending_q;
	assign hresp                  = 1'b0;
	assign hrdata                 = hrdata_q;
	assign regulator_enable       = regulator_q;
	assign address_source         = dev_q.addr_sel;
	assign addr_gpio_sample       = gpio_sample_q;
	assign auto_address_mode      = auto_mode_q;
	assign comp_ctrl              = comp_q;
	assign fault_autoclear        = dev_q.fault_autoclear; // [RL7]
	assign frontend_power_control = pctl_applied_q;
	assign conv_start             = conv_pulse;
	assign link_cfg               = link_q;
	assign baud_tick              = baud_tick_q;
	assign tx_out                 = tx_q;
	assign tx_oe                  = 1'b1; // [RL12]
	assign fault_n_out            = fault_n_q;
	assign fault_n_oe             = 1'b1; // [RL12]
endmodule : comm_config_regs

// ---- tb/cfg_bank_monitor.sv ----
// concurrent checks on the configuration bank ports
// assumes one AHB-Lite master that never overlaps two transfers
`timescale 1ns/100ps
module cfg_bank_monitor (
	input wire logic                sys_clk,                 // clock
	input wire logic                reset,                   // sync reset
	input wire logic                hsel,                    // select
	input wire logic         [31:0] haddr,                   // address
	input wire logic         [1:0]  htrans,                  // transfer type
	input wire logic                hwrite,                  // write
	input wire logic         [31:0] hwdata,                  // write data
	input wire logic                hready,                  // bus ready
	input wire logic                hreadyout,               // slave ready
	input wire logic         [31:0] hrdata,                  // read data
	input wire logic                comm_reset,              // comm reset
	input wire logic                system_reset_fault_flag, // fault flag
	input wire logic                sample_request,          // request
	input wire logic                sample_taken,            // sample done
	input wire logic                regulator_enable,        // regulator
	input wire logic                address_source,          // addr source
	input wire logic                fault_autoclear,         // autoclear
	input wire logic                frontend_power_control,  // applied pctl
	input wire logic                conv_start,              // conversion
	input wire cfg_pkg::comp_ctrl_t comp_ctrl,               // comparators
	input wire cfg_pkg::link_cfg_t  link_cfg,                // link settings
	input wire logic                tx_out,                  // tx level
	input wire logic                fault_n_out              // fault level
);
	import cfg_pkg::*;
	logic        acc_q;
	logic        wr_q;
	logic [31:0] adr_q;
	logic [11:0] cnt_q;
	logic        pc_q;
	logic        dwr;
	logic        drd;
	assign dwr = acc_q && wr_q && hreadyout;
	assign drd = acc_q && !wr_q && hreadyout;
	// data phase marker
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			acc_q <= 1'b0;
		end else if (hsel && htrans[1] && hready) begin
			acc_q <= 1'b1;
		end else if (hreadyout) begin
			acc_q <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (hsel && htrans[1] && hready) begin
			wr_q <= hwrite;
			adr_q <= haddr;
		end
	end
	// cycles since a sample request
	always_ff @(posedge sys_clk) begin
		if (reset || conv_start) begin
			cnt_q <= 12'h000;
			pc_q <= 1'b0;
		end else if (sample_request && cnt_q == 12'h000) begin
			cnt_q <= 12'h001;
			pc_q <= frontend_power_control;
		end else if (cnt_q != 12'h000) begin
			cnt_q <= cnt_q + 12'h001;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_reg_drive; dwr && adr_q == 32'h38 && !system_reset_fault_flag ##1
		!system_reset_fault_flag |=> regulator_enable == !$past(hwdata[5], 2); endproperty
	a_reg_drive: assert property (p_reg_drive) else $error("regulator drive wrong");
	property p_reg_fault; system_reset_fault_flag |=> regulator_enable; endproperty
	a_reg_fault: assert property (p_reg_fault) else $error("regulator not forced");
	property p_dev_bits; dwr && adr_q == 32'h38 |=> address_source == $past(hwdata[4])
		&& fault_autoclear == $past(hwdata[0]); endproperty
	a_dev_bits: assert property (p_dev_bits) else $error("device bits wrong");
	property p_comp; dwr && adr_q == 32'h38 |-> ##2 comp_ctrl == {$past(hwdata[3:2], 2) < 2'h2,
		$past(hwdata[3:2], 2) == 2'h0, $past(hwdata[1], 2)}; endproperty
	a_comp: assert property (p_comp) else $error("comparator decode wrong");
	property p_conv; cnt_q != 12'h000 || conv_start |->
		conv_start == (cnt_q == (pc_q ? 12'h7d1 : 12'h001)); endproperty
	a_conv: assert property (p_conv) else $error("conversion start mistimed");
	property p_pctl; !sample_taken |=> $stable(frontend_power_control); endproperty
	a_pctl: assert property (p_pctl) else $error("power control applied early");
	property p_baud_rst; comm_reset |=> link_cfg.baud == 2'h1; endproperty
	a_baud_rst: assert property (p_baud_rst) else $error("rate not restored");
	property p_host_off; !link_cfg.host_tx_en |=> tx_out && !fault_n_out; endproperty
	a_host_off: assert property (p_host_off) else $error("host pins wrong");
	property p_link_wr; dwr && adr_q == 32'h40 && !comm_reset |=>
		link_cfg == {$past(hwdata[13:12]), $past(hwdata[7:3])}; endproperty
	a_link_wr: assert property (p_link_wr) else $error("link fields wrong");
	property p_rsvd; drd && adr_q == 32'h40 |-> (hrdata & 32'hffffcf07) == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits read back");
	property p_hold; !(dwr && adr_q == 32'h40) && !comm_reset |=> $stable(link_cfg); endproperty
	a_hold: assert property (p_hold) else $error("link settings drifted");
endmodule : cfg_bank_monitor
bind comm_config_regs cfg_bank_monitor mon (.*);

// ---- tb/ahb_host.sv ----
// AHB-Lite master standing in for the host controller
// assumes one slave whose hreadyout comes back as hready
`timescale 1ns/100ps
module ahb_host (
	input  wire logic        sys_clk, // clock
	input  wire logic        hready,  // bus ready
	input  wire logic [31:0] hrdata,  // read data
	output logic             hsel,    // select
	output logic      [31:0] haddr,   // address
	output logic      [1:0]  htrans,  // transfer type
	output logic             hwrite,  // write
	output logic      [2:0]  hsize,   // size
	output logic      [31:0] hwdata   // write data
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// single word transfer; released address and data lines show inverses
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~a;
		hwdata <= (a == 32'h38) ? {d[31:8], 2'h0, d[5:0]} : d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		r = hrdata;
		hwdata <= ~hwdata;
	endtask : xfer
endmodule : ahb_host

// ---- tb/tb_top.sv ----
// self-checking bench for the configuration bank
// assumes the bank is the only AHB-Lite slave
`timescale 1ns/100ps
`define CHECK_EQ(nm, exp, got) begin compares++; if ((got) !== (exp)) begin failures++; \
	$display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top;
	import cfg_pkg::*;
	logic        sys_clk, reset, hsel, hwrite, hreadyout, hresp, fault_flag, host_tx_data;
	logic        fault_n_in, regulator_enable, address_source, addr_gpio_sample, auto_address_mode;
	logic        fault_autoclear, frontend_power_control, conv_start, frontend_busy, baud_tick;
	logic        tx_out, tx_oe, fault_n_out, fault_n_oe, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  pin_q; // comm rst, sample req, sample taken, frame
	comp_ctrl_t  comp_ctrl;
	link_cfg_t   link_cfg;
	int          failures = 0;
	int          compares = 0;
	int          n, k;
	logic [31:0] rows [0:6][0:2] = '{'{32'h38, 32'hff, 32'h3f}, '{32'h38, 32'h15, 32'h15},
		'{32'h3c, 32'h80, 32'h80}, '{32'h40, 32'hffff, 32'h30f8}, '{32'h40, 32'h2058, 32'h2058},
		'{32'h90, 32'h1234, 32'h0}, '{32'h84, 32'h5, 32'h5}};
	comm_config_regs dut (.*, .hready(hreadyout), .comm_reset(pin_q[0]), .sample_request(pin_q[1]),
		.sample_taken(pin_q[2]), .frame_received(pin_q[3]), .system_reset_fault_flag(fault_flag));
	ahb_host host (.*, .hready(hreadyout));
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd);
	endtask : wr
	task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0, rd);
		`CHECK_EQ(nm, {1'b0, e}, {hresp, rd})
	endtask : rdchk
	task automatic settle(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic pulse(input int i);
		@(posedge sys_clk);
		pin_q[i] <= 1'b1;
		@(posedge sys_clk);
		pin_q[i] <= 1'b0;
	endtask : pulse
	// edges from request to conversion, and busy cycles
	task automatic conv_time(input int e);
		pulse(1);
		n = 0;
		k = 0;
		do begin
			@(posedge sys_clk);
			n++;
			k += frontend_busy;
		end while (conv_start !== 1'b1 && n < 3000);
		`CHECK_EQ("conv delay", {e, e - 1}, {n, k})
	endtask : conv_time
	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		conclude();
	end
	initial begin
		reset = 1'b1;
		pin_q = 4'h0;
		fault_flag = 1'b0;
		host_tx_data = 1'b0;
		fault_n_in = 1'b1;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			wr(rows[i][0], rows[i][1]);
			rdchk("readback", rows[i][0], rows[i][2]);
		end
		$display("test register table done");
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		rdchk("dev reset", 32'h38, 32'h0);
		rdchk("pwr reset", 32'h3c, 32'h0);
		rdchk("link reset", 32'h40, 32'h10f8);
		rdchk("status reset", 32'h80, 32'h0);
		`CHECK_EQ("reg reset", 1'b1, regulator_enable)
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			wr(32'h38, {28'h0, c[1:0], c[0], 1'b0});
			settle(3);
			`CHECK_EQ("comparators", {c < 2, c == 0, c[0]}, comp_ctrl)
		end
		wr(32'h38, 32'h21);
		settle(3);
		`CHECK_EQ("reg off", 1'b0, regulator_enable)
		`CHECK_EQ("autoclear", 1'b1, fault_autoclear)
		@(posedge sys_clk);
		fault_flag <= 1'b1;
		settle(2);
		`CHECK_EQ("reg forced", 1'b1, regulator_enable)
		@(posedge sys_clk);
		fault_flag <= 1'b0;
		settle(3);
		`CHECK_EQ("reg released", 1'b0, regulator_enable)
		wr(32'h38, 32'h10);
		wr(32'h8c, 32'h1);
		settle(1);
		`CHECK_EQ("auto mode", 1'b1, auto_address_mode)
		`CHECK_EQ("addr source", 1'b1, address_source)
		pulse(3);
		settle(1);
		`CHECK_EQ("auto ended", 1'b0, auto_address_mode)
		wr(32'h38, 32'h0);
		wr(32'h8c, 32'h1);
		k = 0;
		repeat (4) begin
			@(posedge sys_clk);
			if (addr_gpio_sample === 1'b1) k++;
		end
		`CHECK_EQ("gpio sample pulses", 1, k)
		$display("test device config done");
		wr(32'h40, 32'h1078);
		settle(3);
		`CHECK_EQ("link fields", 7'h2f, link_cfg)
		`CHECK_EQ("host off pins", 4'hb, {tx_out, fault_n_out, tx_oe, fault_n_oe})
		wr(32'h40, 32'h10f8);
		settle(3);
		`CHECK_EQ("host on pins", 4'h7, {tx_out, fault_n_out, tx_oe, fault_n_oe})
		for (int c = 0; c < 4; c++) begin
			wr(32'h40, {18'h0, c[1:0], 12'h0f8});
			n = 0;
			k = 0;
			while (k < 2 && n < 400) begin
				@(posedge sys_clk);
				n++;
				if (baud_tick === 1'b1) begin
					k++;
					if (k == 1) n = 0;
				end
			end
			`CHECK_EQ("bit period", 20000 / (125 << c), n)
		end
		pulse(0);
		rdchk("comm reset rate", 32'h40, 32'h10f8);
		$display("test link config done");
		wr(32'h3c, 32'h80);
		settle(2);
		`CHECK_EQ("pctl deferred", 1'b0, frontend_power_control)
		pulse(2);
		settle(1);
		`CHECK_EQ("pctl applied", 1'b1, frontend_power_control)
		conv_time(100 * 20 + 1);
		conv_time(100 * 20 + 1);
		wr(32'h3c, 32'h0);
		pulse(2);
		conv_time(1);
		$display("test power config done");
		rdchk("status", 32'h80, 32'hf);
		`CHECK_EQ("irq masked", 1'b0, irq)
		wr(32'h84, 32'h4);
		settle(1);
		`CHECK_EQ("irq raised", 1'b1, irq)
		wr(32'h88, 32'h4);
		settle(1);
		`CHECK_EQ("irq cleared", 1'b0, irq)
		wr(32'h80, 32'h0);
		rdchk("status after clear", 32'h80, 32'hb);
		rdchk("clear reads zero", 32'h88, 32'h0);
		$display("test interrupts done");
		conclude();
	end
endmodule : tb_top
